// ### core/psmc_pkg.sv
package psmc_pkg;
    // sfr addresses
    localparam logic [7:0] ADDR_POWER_MODE_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_POWER_MODE_WAKE    = 8'h88;
    localparam logic [7:0] ADDR_SYSTEM_CONTROL     = 8'hB1;
    // reset images
    localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h00;
    localparam logic [2:0] SYNC_EXT_INTERRUPT0_PIN_IDLE     = 3'h7;
    localparam logic [2:0] SYNC_USB_IDLE      = 3'h0;
    // system control field
    localparam int BIT_SFR_MAP_SELECT = 4;
    // power mode control fields
    localparam int BIT_POWERDOWN_START = 6;
    localparam int BIT_IDLE_START      = 5;
    localparam int BIT_USER_FLAG_1     = 3;
    localparam int BIT_USER_FLAG_0     = 2;
    localparam int BIT_POWERDOWN_ARM   = 1;
    localparam int BIT_IDLE_ARM        = 0;
    // wake control fields
    localparam int BIT_EXT_WAKE_ENABLE = 7;
    localparam int BIT_WAKE_SOURCE     = 4;
    // wake source encodings
    localparam logic WAKE_SRC_PIN = 1'b0;
    localparam logic WAKE_SRC_USB = 1'b1;
    // mode states, one-hot
    typedef enum logic [2:0] {
        PSMC_RUN  = 3'h1,
        PSMC_IDLE = 3'h2,
        PSMC_PDN  = 3'h4
    } psmc_state_t;
endpackage

// ### core/psmc_power_mode_ctrl.sv
// Summary of operation
// R1 - power mode control register decoded at sfr address 87 hex
// R2 - wake control register at mapped 88 hex, only with map select set
// R3 - map select is bit 4 of system control at B1 hex
// R4 - powerdown arm/start pick power-down; idle arm/start pick idle
// R5 - simultaneous power-down and idle requests enter power-down only
// R6 - control layout: pd start 6, idle start 5, flags 3:2, arms 1:0
// R7 - two user flags, freely read/written, no hardware effect
// R8 - powerdown start ignored unless powerdown arm already set
// R9 - idle start ignored unless idle arm already set
// R10 - external wake enable must be set for pin or usb wake
// R11 - wake source select: 0 pin (default), 1 usb activity
// R12 - wake control: ext wake enable bit 7, wake source bit 4
// R13 - software must not rely on reserved bits
// R14 - idle needs arm write then separate start write; both together fail
// R15 - idle arm and start self clear and always read zero
// R16 - idle ends on enabled interrupt or reset
// R17 - power-down ends on reset, low pin, or usb; registers kept
// R18 - power-down needs arm write then separate start write
`timescale 1ns/1ps
`default_nettype none
module psmc_power_mode_ctrl (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    input  wire logic       irq_pending,
    input  wire logic       ext_interrupt0_pin,
    input  wire logic       usb_bus_activity,
    output logic            cpu_clock_gate,
    output logic            oscillator_stop,
    output logic            wake_event
);
    // mode state and register image
    psmc_pkg::psmc_state_t state_reg;
    logic       powerdown_start_reg;
    logic       user_flag_1_reg;
    logic       user_flag_0_reg;
    logic       powerdown_arm_reg;
    logic       idle_arm_reg;
    logic       external_wake_enable_reg;
    logic       wake_source_select_reg;
    logic       sfr_map_select_reg;
    logic [7:0] system_control_reg;

    // pin synchronisers and their filtered levels
    logic [2:0] ext_interrupt0_pin_sync_reg;
    logic [2:0] usb_sync_reg;
    logic       ext_interrupt0_pin_low_reg;
    logic       usb_act_reg;

    // decoded strobes and mode requests
    logic       wr_ctrl;
    logic       wr_wake;
    logic       wr_sys;
    logic       rd_ctrl;
    logic       rd_wake;
    logic       rd_sys;
    logic       wake_mapped;
    logic       pd_go;
    logic       idle_go;
    logic       pd_wake;

    // address match, shared by the write and the read decode
    function automatic logic addr_is(
        input logic [7:0] addr,
        input logic [7:0] target
    );
        return addr == target;
    endfunction

    // last two taps agree; a one-sample glitch is never acted on
    function automatic logic taps_agree(
        input logic [2:0] taps
    );
        return taps[1] == taps[2];
    endfunction

    // a start counts only on its own write after the arm was set
    function automatic logic start_ok(
        input logic armed,
        input logic start_bit,
        input logic arm_bit
    );
        return armed && start_bit && !arm_bit;
    endfunction

    // control register as software sees it; idle bits never read back
    function automatic logic [7:0] ctrl_view(
        input logic pd_start,
        input logic flag_1,
        input logic flag_0,
        input logic pd_arm
    );
        logic [7:0] view;
        view = 8'h00;
        view[psmc_pkg::BIT_POWERDOWN_START] = pd_start;
        view[psmc_pkg::BIT_USER_FLAG_1]     = flag_1;
        view[psmc_pkg::BIT_USER_FLAG_0]     = flag_0;
        view[psmc_pkg::BIT_POWERDOWN_ARM]   = pd_arm;
        return view; // R15
    endfunction

    // wake control as software sees it; reserved bits read zero
    function automatic logic [7:0] wake_view(
        input logic wake_enable,
        input logic wake_source
    );
        logic [7:0] view;
        view = 8'h00;
        view[psmc_pkg::BIT_EXT_WAKE_ENABLE] = wake_enable;
        view[psmc_pkg::BIT_WAKE_SOURCE]     = wake_source;
        return view; // R12
    endfunction

    // the wake register only exists in the mapped area
    assign wake_mapped =
        sfr_map_select_reg &&
        addr_is(sfr_addr, psmc_pkg::ADDR_POWER_MODE_WAKE); // R2

    // write decode; a write to the wake slot without map select is lost
    assign wr_ctrl =
        sfr_wr && addr_is(sfr_addr, psmc_pkg::ADDR_POWER_MODE_CONTROL); // R1
    assign wr_wake = sfr_wr && wake_mapped; // R2
    assign wr_sys  =
        sfr_wr && addr_is(sfr_addr, psmc_pkg::ADDR_SYSTEM_CONTROL); // R3

    // read decode mirrors the write decode
    assign rd_ctrl =
        sfr_rd && addr_is(sfr_addr, psmc_pkg::ADDR_POWER_MODE_CONTROL); // R1
    assign rd_wake = sfr_rd && wake_mapped; // R2
    assign rd_sys  =
        sfr_rd && addr_is(sfr_addr, psmc_pkg::ADDR_SYSTEM_CONTROL); // R3

    // start only counts if the arm was set by an earlier write
    assign pd_go = wr_ctrl &&
                   start_ok(powerdown_arm_reg,
                            sfr_wdata[psmc_pkg::BIT_POWERDOWN_START],
                            sfr_wdata[psmc_pkg::BIT_POWERDOWN_ARM]); // R8 R18
    assign idle_go = wr_ctrl &&
                     start_ok(idle_arm_reg,
                              sfr_wdata[psmc_pkg::BIT_IDLE_START],
                              sfr_wdata[psmc_pkg::BIT_IDLE_ARM]); // R9 R14

    // wake needs the enable; source picks pin level or usb activity
    assign pd_wake = external_wake_enable_reg &&
                     (wake_source_select_reg == psmc_pkg::WAKE_SRC_USB ?
                      usb_act_reg : ext_interrupt0_pin_low_reg); // R10 R11 R17

    // system control register; only map select matters here
    always_ff @(posedge clk) begin
        if (!rstn) begin
            system_control_reg <= psmc_pkg::RST_SYSTEM_CONTROL;
        end else if (wr_sys) begin
            system_control_reg <= sfr_wdata;
        end
    end
    assign sfr_map_select_reg =
        system_control_reg[psmc_pkg::BIT_SFR_MAP_SELECT]; // R3

    // power mode control register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            powerdown_start_reg <= 1'b0;
            user_flag_1_reg     <= 1'b0;
            user_flag_0_reg     <= 1'b0;
            powerdown_arm_reg   <= 1'b0;
            idle_arm_reg        <= 1'b0;
        end else if (wr_ctrl) begin
            user_flag_1_reg <= sfr_wdata[psmc_pkg::BIT_USER_FLAG_1]; // R7
            user_flag_0_reg <= sfr_wdata[psmc_pkg::BIT_USER_FLAG_0]; // R7
            powerdown_arm_reg <= sfr_wdata[psmc_pkg::BIT_POWERDOWN_ARM]; // R6
            powerdown_start_reg <= pd_go; // R8
            // idle arm holds for one following write only
            idle_arm_reg <= sfr_wdata[psmc_pkg::BIT_IDLE_ARM] &&
                            !sfr_wdata[psmc_pkg::BIT_IDLE_START]; // R14
        end else if (state_reg == psmc_pkg::PSMC_RUN) begin
            // start bit drops once the mode has been left
            powerdown_start_reg <= 1'b0;
        end
    end

    // wake control register, kept across non-reset wake-ups
    always_ff @(posedge clk) begin
        if (!rstn) begin
            external_wake_enable_reg <= 1'b0;
            wake_source_select_reg   <= psmc_pkg::WAKE_SRC_PIN; // R11
        end else if (wr_wake) begin
            external_wake_enable_reg <=
                sfr_wdata[psmc_pkg::BIT_EXT_WAKE_ENABLE]; // R12
            wake_source_select_reg <=
                sfr_wdata[psmc_pkg::BIT_WAKE_SOURCE]; // R12
        end
    end

    // wake pin through three flops; idles high so reset makes no edge
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ext_interrupt0_pin_sync_reg <= psmc_pkg::SYNC_EXT_INTERRUPT0_PIN_IDLE;
            ext_interrupt0_pin_low_reg  <= 1'b0;
        end else begin
            ext_interrupt0_pin_sync_reg <= {ext_interrupt0_pin_sync_reg[1:0], ext_interrupt0_pin};
            if (taps_agree(ext_interrupt0_pin_sync_reg)) begin
                ext_interrupt0_pin_low_reg <= !ext_interrupt0_pin_sync_reg[2]; // R17
            end
        end
    end

    // usb activity through three flops, same filtering as the pin
    always_ff @(posedge clk) begin
        if (!rstn) begin
            usb_sync_reg <= psmc_pkg::SYNC_USB_IDLE;
            usb_act_reg  <= 1'b0;
        end else begin
            usb_sync_reg <= {usb_sync_reg[1:0], usb_bus_activity};
            if (taps_agree(usb_sync_reg)) begin
                usb_act_reg <= usb_sync_reg[2]; // R17
            end
        end
    end

    // wake pulse; one cycle, only for a non-reset exit
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wake_event <= 1'b0;
        end else begin
            case (state_reg)
                psmc_pkg::PSMC_IDLE: begin
                    wake_event <= !pd_go && irq_pending; // R16
                end
                psmc_pkg::PSMC_PDN: begin
                    wake_event <= pd_wake; // R17
                end
                default: begin
                    wake_event <= 1'b0;
                end
            endcase
        end
    end

    // mode sequencer; power-down wins over idle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg <= psmc_pkg::PSMC_RUN; // R16 R17
        end else begin
            case (state_reg)
                psmc_pkg::PSMC_RUN: begin
                    if (pd_go) begin
                        state_reg <= psmc_pkg::PSMC_PDN; // R4 R5
                    end else if (idle_go) begin
                        state_reg <= psmc_pkg::PSMC_IDLE; // R4
                    end
                end
                psmc_pkg::PSMC_IDLE: begin
                    if (pd_go) begin
                        state_reg <= psmc_pkg::PSMC_PDN; // R5
                    end else if (irq_pending) begin
                        state_reg <= psmc_pkg::PSMC_RUN; // R16
                    end
                end
                psmc_pkg::PSMC_PDN: begin
                    if (pd_wake) begin
                        state_reg <= psmc_pkg::PSMC_RUN; // R17
                    end
                end
                default: begin
                    state_reg <= psmc_pkg::PSMC_RUN;
                end
            endcase
        end
    end

    // cpu clock gate, on in both modes; a cycle late behind the state
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cpu_clock_gate <= 1'b0;
        end else begin
            cpu_clock_gate <= state_reg != psmc_pkg::PSMC_RUN; // R4
        end
    end

    // oscillator stop, power-down only
    always_ff @(posedge clk) begin
        if (!rstn) begin
            oscillator_stop <= 1'b0;
        end else begin
            oscillator_stop <= state_reg == psmc_pkg::PSMC_PDN; // R4 R5
        end
    end

    // read data stands until the next read; unmapped slots read zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sfr_rdata <= 8'h00;
        end else if (rd_ctrl) begin
            sfr_rdata <= ctrl_view(powerdown_start_reg,
                                   user_flag_1_reg,
                                   user_flag_0_reg,
                                   powerdown_arm_reg); // R7 R15
        end else if (rd_wake) begin
            sfr_rdata <= wake_view(external_wake_enable_reg,
                                   wake_source_select_reg); // R12
        end else if (rd_sys) begin
            sfr_rdata <= system_control_reg; // R3
        end else if (sfr_rd) begin
            sfr_rdata <= 8'h00; // R1
        end
    end
endmodule
`default_nettype wire

// ### dv/psmc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module psmc_asserts (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic       irq_pending,
    input wire logic       cpu_clock_gate,
    input wire logic       oscillator_stop,
    input wire logic       wake_event
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // a start write to the control register, needed before any gating
    logic start_wr;
    assign start_wr = sfr_wr && sfr_addr == 8'h87
                      && (sfr_wdata[5] || sfr_wdata[6]);
    // wake pulse, then both mode outputs drop
    sequence s_drop;
        wake_event ##1 (!cpu_clock_gate && !oscillator_stop);
    endsequence
    property p_pd_gate; oscillator_stop |-> cpu_clock_gate; endproperty
    a_pd_gate: assert property (p_pd_gate) else $error("stop, no gate");
    property p_rst;
        disable iff (1'b0)
        !rstn |=> !cpu_clock_gate && !oscillator_stop && !wake_event;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs in reset");
    property p_pulse; wake_event |=> !wake_event; endproperty
    a_pulse: assert property (p_pulse) else $error("wake too long");
    property p_drop; wake_event |-> s_drop; endproperty
    a_drop: assert property (p_drop) else $error("mode kept");
    property p_irq;
        cpu_clock_gate && !oscillator_stop && irq_pending && !wake_event
        |-> ##[1:2] wake_event;
    endproperty
    a_irq: assert property (p_irq) else $error("idle not left");
    property p_start;
        $rose(cpu_clock_gate)
        |-> $past(start_wr, 1) || $past(start_wr, 2) || $past(start_wr, 3);
    endproperty
    a_start: assert property (p_start) else $error("gate, no start");
    property p_rd_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
    property p_rd_idle;
        sfr_rd && sfr_addr == 8'h87 |=> !sfr_rdata[5] && !sfr_rdata[0];
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("idle bit");
    property p_unmapped;
        sfr_rd && !(sfr_addr inside {8'h87, 8'h88, 8'hB1})
        |=> sfr_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped");
endmodule
bind psmc_power_mode_ctrl psmc_asserts psmc_asserts_inst (
    .clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .irq_pending(irq_pending), .cpu_clock_gate(cpu_clock_gate),
    .oscillator_stop(oscillator_stop), .wake_event(wake_event));
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic       irq = 1'b0, pin = 1'b1, usb = 1'b0, gate, stop, wake;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    int         n_fail = 0, n_checks = 0;
    // 40 MHz
    always #12.5 clk = ~clk;
    psmc_power_mode_ctrl psmc_power_mode_ctrl_inst (
        .clk(clk), .rstn(rstn), .sfr_addr(addr), .sfr_wdata(wdata),
        .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdata), .irq_pending(irq),
        .ext_interrupt0_pin(pin), .usb_bus_activity(usb),
        .cpu_clock_gate(gate), .oscillator_stop(stop), .wake_event(wake));
    task automatic chk(input string what, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic conclude;
        if (n_fail == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one-cycle strobe; the gap after it keeps writes apart
    task automatic wr_reg(input logic [7:0] a, d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    // masked compare, reserved bits are not relied on
    task automatic rd_reg(input logic [7:0] a, e, m);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        chk("rdata", e, rdata & m);
    endtask
    task automatic modes(input logic g, s);
        chk("gate_stop", {6'h00, g, s}, {6'h00, gate, stop});
    endtask
    // bounded wait; a missing pulse ends the run
    task automatic wait_wake;
        for (int i = 0; i < 20 && wake !== 1'b1; i++) @(negedge clk);
        chk("wake", 8'h01, {7'h00, wake});
        if (wake !== 1'b1) conclude();
        cyc(2);
        modes(1'b0, 1'b0);
    endtask
    task automatic pd_enter;
        wr_reg(8'h87, 8'h02);
        wr_reg(8'h87, 8'h40);
        cyc(4);
        modes(1'b1, 1'b1);
    endtask
    initial begin
        cyc(10);
        rstn = 1'b1;
        rd_reg(8'h87, 8'h00, 8'hFF);
        rd_reg(8'hB1, 8'h00, 8'hFF);
        rd_reg(8'h88, 8'h00, 8'hFF);
        rd_reg(8'h55, 8'h00, 8'hFF);
        wr_reg(8'h87, 8'h0C);
        rd_reg(8'h87, 8'h0C, 8'hFF);
        wr_reg(8'h87, 8'h21);
        cyc(4);
        modes(1'b0, 1'b0);
        wr_reg(8'h87, 8'h20);
        cyc(4);
        modes(1'b0, 1'b0);
        wr_reg(8'h87, 8'h0D);
        wr_reg(8'h87, 8'h2C);
        cyc(4);
        modes(1'b1, 1'b0);
        rd_reg(8'h87, 8'h0C, 8'hFF);
        irq = 1'b1;
        wait_wake();
        irq = 1'b0;
        wr_reg(8'h87, 8'h40);
        cyc(4);
        modes(1'b0, 1'b0);
        wr_reg(8'hB1, 8'h10);
        wr_reg(8'h88, 8'h90);
        rd_reg(8'h88, 8'h90, 8'h90);
        pd_enter();
        rd_reg(8'h87, 8'h40, 8'h42);
        usb = 1'b1;
        wait_wake();
        usb = 1'b0;
        rd_reg(8'h88, 8'h90, 8'h90);
        wr_reg(8'h88, 8'h80);
        wr_reg(8'h87, 8'h03);
        wr_reg(8'h87, 8'h60);
        cyc(4);
        modes(1'b1, 1'b1);
        pin = 1'b0;
        wait_wake();
        pin = 1'b1;
        wr_reg(8'h88, 8'h10);
        pd_enter();
        pin = 1'b0;
        usb = 1'b1;
        cyc(10);
        modes(1'b1, 1'b1);
        pin = 1'b1;
        usb = 1'b0;
        rstn = 1'b0;
        cyc(2);
        rstn = 1'b1;
        cyc(1);
        modes(1'b0, 1'b0);
        wr_reg(8'h88, 8'h90);
        wr_reg(8'hB1, 8'h10);
        rd_reg(8'h88, 8'h00, 8'hFF);
        conclude();
    end
endmodule
`default_nettype wire
